/* testbench/fcp_link_monitor.sv */
/*
  Checker of the link between controller and flash.
  Assumes every link signal is sampled on the core clock.
*/
module fcp_link_monitor (
  input wire logic       I_CORE_CLK,
  input wire logic       I_RESETN,
  input wire logic       sclk,
  input wire logic       cs_n,
  input wire logic [3:0] h_o,
  input wire logic [3:0] h_oe,
  input wire logic [3:0] d_o,
  input wire logic [3:0] d_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       sclk_q;
  logic [7:0] rise_q;
  default clocking @(posedge I_CORE_CLK);
  endclocking
  default disable iff (!I_RESETN);
  ////////////////////////////////////////////////////////////////////////
  // Delayed link clock
  always_ff @(posedge I_CORE_CLK or negedge I_RESETN)
    if (!I_RESETN)
      sclk_q <= 1'b0;
    else
      sclk_q <= sclk;
  // Rising link edges within the frame
  always_ff @(posedge I_CORE_CLK or negedge I_RESETN)
    if (!I_RESETN)
      rise_q <= 8'h00;
    else
      rise_q <= cs_n ? 8'h00 : rise_q + {7'h00, sclk & ~sclk_q};
  ////////////////////////////////////////////////////////////////////////
  // Wire rules
  idle_low_a: assert property (cs_n |-> !sclk)
    else $error("link clock moves outside a frame");
  half_a: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
    else $error("link clock high phase wrong");
  in_hold_a: assert property ($rose(sclk) |-> $stable(h_o) && $stable(h_oe))
    else $error("host data moved at rising edge");
  out_hold_a: assert property (sclk && $past(sclk) && d_oe != 4'h0 |-> $stable(d_o))
    else $error("flash data moved while clock high");
  no_clash_a: assert property ((h_oe & d_oe) == 4'h0)
    else $error("both ends drive a line");
  dev_lines_a: assert property (d_oe != 4'h0 |-> d_oe inside {4'h2, 4'hf})
    else $error("flash drives wrong lines");
  quiet_a: assert property (!cs_n && rise_q < 8'd2 |-> d_oe == 4'h0)
    else $error("flash drives during opcode");
  release_a: assert property (cs_n [*6] |-> d_oe == 4'h0)
    else $error("flash drives outside frame");
  whole_a: assert property ($rose(cs_n) |-> rise_q[0] == 1'b0)
    else $error("frame ends in mid unit");
endmodule

/* testbench/tb_flash_config_protect_cmds.sv */
/*
  Bench joining controller and flash over the link, driven by the software port.
  Assumes the controller frames every command that the flash sees.
*/
`include "fcp_map.svh"
module tb_flash_config_protect_cmds;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, rst_n = 1'b0, quad = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [7:0]  addr = 8'h00, bank, bank_nv;
  logic [31:0] wdata = 32'h0, rdata, last, boot, q;
  logic [3:0]  dly;
  logic        write_in_progress, write_enable_latch, busy, seen;
  int          err_total = 0, checks = 0, cyc = 0;
  fcp_link_if link ();
  fcp_host fcp_host_i (.I_CORE_CLK(clk), .I_RESETN(rst_n), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .O_BUSY(busy), .LINK(link.host));
  fcp_dev fcp_dev_i (.I_CORE_CLK(clk), .I_RESETN(rst_n), .I_QUAD_MODE(quad), .LINK(link.dev),
    .O_WIP(write_in_progress), .O_WEL(write_enable_latch), .O_BANK_REG(bank), .O_BANK_NV(bank_nv), .O_BOOT_CFG(boot),
    .O_BOOT_DELAY(dly), .O_LAST_ADDR(last));
  fcp_link_monitor fcp_link_monitor_i (.I_CORE_CLK(clk), .I_RESETN(rst_n), .sclk(link.sclk),
    .cs_n(link.cs_n), .h_o(link.h_o), .h_oe(link.h_oe), .d_o(link.d_o), .d_oe(link.d_oe));
  ////////////////////////////////////////////////////////////////////////
  // Core clock and hang guard
  always #25 clk = ~clk;
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      err_total++;
      stop_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Verdict
  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", err_total, checks);
    if (err_total == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Compare one result
  task automatic chk(input logic [40:0] got, input logic [40:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One register write on the software port
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // One command, wait for link and flash idle, then fetch the read bytes
  task automatic run(input logic [7:0] op, input logic [2:0] ab, db, rb,
                     input logic w, input logic [31:0] a, d);
    int n;
    n    = 0;
    seen = 1'b0;
    wreg(`FCP_REG_ADDR, a);
    wreg(`FCP_REG_WDATA, d);
    wreg(`FCP_REG_CMD, {13'h0, w, quad, rb, db, ab, op});
    repeat (2) @(posedge clk);
    while ((busy !== 1'b0 || write_in_progress !== 1'b0) && n < 4000)
    begin
      if (write_in_progress === 1'b1)
        seen = 1'b1;
      @(posedge clk);
      n++;
    end
    // A command that never finishes counts as a mismatch
    if (n >= 4000)
    begin
      err_total++;
      $display("[ERR] %0t command did not finish", $time);
    end
    @(posedge clk);
    addr <= `FCP_REG_RDATA;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 q = rdata;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Boot register: refusals, exact length, write and read back
  task automatic t_boot();
    run(`FCP_OP_BOOT_WR, 0, 4, 0, 0, 0, 32'h12345678);
    run(`FCP_OP_BANK_WRVE, 0, 1, 0, 0, 0, 1);
    chk({seen, boot, bank}, 0);
    run(`FCP_OP_BOOT_WR, 0, 3, 0, 1, 0, 32'h12345678);
    chk(boot, 0);
    run(`FCP_OP_BOOT_WR, 0, 4, 0, 1, 0, 32'h12345678);
    chk({seen, write_enable_latch, dly, boot}, {2'b10, 4'hc, 32'h12345678});
    run(`FCP_OP_BOOT_RD, 0, 0, 4, 0, 0, 0);
    chk(q, 32'h12345678);
  endtask
  // Bank register writes, reads and address width
  task automatic t_bank();
    run(`FCP_OP_BANK_WRV, 0, 1, 0, 0, 0, 3);
    chk({seen, write_enable_latch, bank}, 10'h203);
    run(`FCP_OP_BANK_RD, 0, 0, 2, 0, 0, 0);
    chk(q, 32'h0303);
    run(`FCP_OP_BANK_RD2, 0, 0, 1, 0, 0, 0);
    chk(q, 32'h03);
    run(`FCP_OP_BANK_WRVE, 0, 1, 0, 1, 0, 1);
    chk(bank, 1);
    run(`FCP_OP_BANK_WRNV, 0, 1, 0, 1, 0, 32'hff);
    chk({bank, bank_nv}, 16'h8383);
    run(`FCP_OP_WIDE_OFF, 0, 0, 0, 0, 0, 0);
    chk({bank, bank_nv}, 16'h0383);
    run(`FCP_OP_WIDE_ON, 0, 0, 0, 0, 0, 0);
    chk({bank, bank_nv}, 16'h8383);
  endtask
  // Dynamic protection with four-byte addresses, persistent protection with three-byte addresses
  task automatic t_prot();
    run(`FCP_OP_DYN_WR, 4, 1, 0, 1, 32'h50000, 0);
    chk(last, 32'h50000);
    run(`FCP_OP_DYN_RD, 4, 0, 2, 0, 32'h50000, 0);
    chk(q, 0);
    run(`FCP_OP_DYN_RD4, 4, 0, 1, 0, 32'h60000, 0);
    chk(q, 32'hff);
    run(`FCP_OP_WIDE_OFF, 0, 0, 0, 0, 0, 0);
    run(`FCP_OP_PP_PG, 3, 0, 0, 1, 32'h50000, 0);
    chk({seen, write_enable_latch, last}, {2'b10, 32'h3050000});
    run(`FCP_OP_PP_RD, 3, 0, 1, 0, 32'h50000, 0);
    chk(q, 0);
  endtask
  // Quad command mode, then persistent erase
  task automatic t_quad();
    @(posedge clk);
    quad <= 1'b1;
    run(`FCP_OP_BANK_RD, 0, 0, 1, 0, 0, 0);
    chk(q, 32'h03);
    run(`FCP_OP_PP_RD4, 4, 0, 1, 0, 32'h70000, 0);
    chk(last, 32'h3050000);
    @(posedge clk);
    quad <= 1'b0;
    run(`FCP_OP_PP_ER, 0, 0, 0, 1, 0, 0);
    chk({seen, write_enable_latch}, 2'b10);
    run(`FCP_OP_PP_RD, 3, 0, 1, 0, 32'h50000, 0);
    chk(q, 32'hff);
    run(`FCP_OP_STAT, 0, 0, 1, 1, 0, 0);
    chk(q, 32'h02);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_boot();
    t_bank();
    t_prot();
    t_quad();
    stop_test();
  end
endmodule

/* verilog/fcp_dev.sv */
/*
  Flash-side command interpreter for boot configuration, bank register,
  address width and per-sector dynamic and persistent protection.
  Assumes the link clock comes from the controller and is slower than a
  third of the core clock; the select is idle high.
*/
// Functional notes
// - boot config read streams 32 bits, repeating
// - boot write needs latch; controller sends write enable only when the command asks
// - boot write exactly 32 data bits, else dropped
// - boot write runs after select rises, busy, clears latch
// - bank read returns volatile byte, repeating
// - single uses one line each way, quad four
// - non-volatile bank write needs latch, sets both
// - C5 needs latch, 17 does not
// - bank bits extend three-byte addresses
// - bank write one byte, busy while updating
// - controller writes reserved bank bits as zero
// - enter wide sets extended bit, no latch
// - exit wide clears extended bit, no latch
// - mode-dependent address length, wide twins four
// - dynamic read repeats sector byte on falls
// - dynamic write: latch, address, one byte
// - persistent read single-line mode only
// - persistent program: latch, address, busy, clears
// - persistent erase sets all, exact opcode frame
// - erase busy, then latch clears, no suspend
// - sample on rises, drive on falls
// - boot config holds start and delay fields
`include "fcp_map.svh"

module fcp_dev #(
  parameter int SECT_BITS = 10,
  parameter int SECT_LSB  = 16,
  parameter int BUSY_CYC  = `FCP_BUSY_CYC
) (
  input  wire logic        I_CORE_CLK,
  input  wire logic        I_RESETN,
  input  wire logic        I_QUAD_MODE,
  fcp_link_if.dev          LINK,
  output logic             O_WIP,
  output logic             O_WEL,
  output logic [7:0]       O_BANK_REG,
  output logic [7:0]       O_BANK_NV,
  output logic [31:0]      O_BOOT_CFG,
  output logic [3:0]       O_BOOT_DELAY,
  output logic [31:0]      O_LAST_ADDR
);
  import fcp_pkg::*;

  localparam int NS = 1 << SECT_BITS;

  typedef struct packed {
    logic            sck_m;
    logic            sck_s;
    logic            sck_p;
    logic            cs_m;
    logic            cs_s;
    logic [3:0]      io_m;
    logic [3:0]      io_s;
    fcp_dst_t        st;
    fcp_cmd_t        cmd;
    logic [7:0]      op;
    logic [6:0]      cnt;
    logic [31:0]     adr;
    logic [31:0]     dat;
    logic [31:0]     out;
    logic [3:0]      drv;
    logic [3:0]      oe;
    logic            write_enable_latch;
    logic            write_in_progress;
    logic            clr;
    logic [15:0]     busy;
    logic [7:0]      bank;
    logic [7:0]      bnv;
    logic [31:0]     boot;
    logic [31:0]     last;
    logic [NS-1:0]   dynamic_protect_bit;
    logic [NS-1:0]   persistent_protect_bit;
  } fcp_dev_st_t;

  fcp_dev_st_t q;
  fcp_dev_st_t d;

  ////////////////////////////////////////////////////////////////////////
  // Decode of an opcode into its frame shape
  function automatic fcp_cmd_t dec(input logic [7:0] op, input logic ext);
    fcp_cmd_t   c;
    logic [6:0] a;
    a = ext ? 7'd32 : 7'd24;
    c = '0;
    c.ok = 1'b1;
    case (op)
      `FCP_OP_WEN, `FCP_OP_WIDE_ON, `FCP_OP_WIDE_OFF: c.rd = 1'b0;
      `FCP_OP_STAT, `FCP_OP_BOOT_RD,
      `FCP_OP_BANK_RD, `FCP_OP_BANK_RD2:              c.rd = 1'b1;
      `FCP_OP_BOOT_WR:
      begin
        c.write_enable_latch  = 1'b1;
        c.dlen = 7'd32;
      end
      `FCP_OP_BANK_WRNV, `FCP_OP_BANK_WRVE:
      begin
        c.write_enable_latch  = 1'b1;
        c.dlen = 7'd8;
      end
      `FCP_OP_BANK_WRV:  c.dlen = 7'd8;
      `FCP_OP_DYN_RD, `FCP_OP_PP_RD:
      begin
        c.rd   = 1'b1;
        c.alen = a;
      end
      `FCP_OP_DYN_RD4, `FCP_OP_PP_RD4:
      begin
        c.rd   = 1'b1;
        c.alen = 7'd32;
      end
      `FCP_OP_DYN_WR, `FCP_OP_DYN_WR4:
      begin
        c.write_enable_latch  = 1'b1;
        c.alen = (op == `FCP_OP_DYN_WR) ? a : 7'd32;
        c.dlen = 7'd8;
      end
      `FCP_OP_PP_PG, `FCP_OP_PP_PG4:
      begin
        c.write_enable_latch  = 1'b1;
        c.alen = (op == `FCP_OP_PP_PG) ? a : 7'd32;
      end
      `FCP_OP_PP_ER: c.write_enable_latch = 1'b1;
      default:       c.ok  = 1'b0;
    endcase
    return c;
  endfunction

  // Effective address, bank byte on top of a three-byte address
  function automatic logic [31:0] eff(input logic [31:0] a, input logic [6:0] al,
                                      input logic [7:0] b);
    return (al == 7'd24) ? {b, a[23:0]} : a;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    logic [6:0]           w;
    logic                 rise;
    logic                 fall;
    logic                 ld;
    logic                 go;
    logic [7:0]           stat;
    logic [31:0]          ea;
    logic [SECT_BITS-1:0] sect;
    fcp_cmd_t             c;
    d    = q;
    w    = I_QUAD_MODE ? 7'd4 : 7'd1;
    rise = q.sck_s & ~q.sck_p;
    fall = ~q.sck_s & q.sck_p;
    ld   = 1'b0;
    go   = 1'b0;
    stat = 8'h00;
    ea   = 32'h0;
    sect = '0;
    c    = '0;
    // Two-stage synchronisers on every link input
    d.sck_m = LINK.sclk;
    d.sck_s = q.sck_m;
    d.sck_p = q.sck_s;
    d.cs_m  = LINK.cs_n;
    d.cs_s  = q.cs_m;
    d.io_m  = LINK.io;
    d.io_s  = q.io_m;
    // Internal write timer; latch clears at completion
    if (q.busy != 16'h0)
    begin
      d.busy = q.busy - 16'h1;
      if (q.busy == 16'h1 && q.clr)
        d.write_enable_latch = 1'b0;
    end
    if (q.cs_s)
    begin
      // Select high: execute a complete frame, exact length only
      if (q.st == DS_ARG && q.cnt == q.cmd.alen + q.cmd.dlen)
      begin
        ea   = eff(q.adr, q.cmd.alen, q.bank);
        sect = ea[SECT_LSB +: SECT_BITS];
        go   = 1'b1;
        case (q.op)
          `FCP_OP_WEN:
          begin
            d.write_enable_latch = 1'b1;
            go    = 1'b0;
          end
          `FCP_OP_BOOT_WR:  d.boot = fcp_bswap(q.dat);
          `FCP_OP_BANK_WRNV:
          begin
            d.bnv  = q.dat[7:0];
            d.bank = q.dat[7:0];
          end
          `FCP_OP_BANK_WRV, `FCP_OP_BANK_WRVE: d.bank = q.dat[7:0];
          `FCP_OP_WIDE_ON:
          begin
            d.bank[`FCP_BANK_EXT] = 1'b1;
            go = 1'b0;
          end
          `FCP_OP_WIDE_OFF:
          begin
            d.bank[`FCP_BANK_EXT] = 1'b0;
            go = 1'b0;
          end
          `FCP_OP_DYN_WR, `FCP_OP_DYN_WR4:
          begin
            d.dynamic_protect_bit[sect] = q.dat[0];
            d.last      = ea;
          end
          `FCP_OP_PP_PG, `FCP_OP_PP_PG4:
          begin
            d.persistent_protect_bit[sect] = 1'b0;
            d.last      = ea;
          end
          `FCP_OP_PP_ER:    d.persistent_protect_bit = '1;
          default:          go = 1'b0;
        endcase
        if (go)
        begin
          d.busy = 16'(BUSY_CYC);
          d.clr  = q.cmd.write_enable_latch;
        end
      end
      d.st  = DS_IDLE;
      d.cnt = 7'd0;
      d.oe  = 4'h0;
    end
    else
    begin
      unique case (q.st)
        DS_IDLE: d.st = DS_OPC;
        DS_OPC:
          if (rise)
          begin
            d.op  = I_QUAD_MODE ? {q.op[3:0], q.io_s} : {q.op[6:0], q.io_s[0]};
            d.cnt = q.cnt + w;
            if (d.cnt == 7'd8)
            begin
              c     = dec(d.op, q.bank[`FCP_BANK_EXT]);
              d.cmd = c;
              d.cnt = 7'd0;
              if (!c.ok || (c.write_enable_latch && !q.write_enable_latch) || (q.write_in_progress && d.op != `FCP_OP_STAT) ||
                  (I_QUAD_MODE && (d.op == `FCP_OP_PP_RD || d.op == `FCP_OP_PP_RD4)))
                d.st = DS_IGN;
              else if (c.rd && c.alen == 7'd0)
              begin
                ld   = 1'b1;
                d.st = DS_OUT;
              end
              else
                d.st = DS_ARG;
            end
          end
        DS_ARG:
          if (rise)
          begin
            if (q.cnt < q.cmd.alen)
              d.adr = I_QUAD_MODE ? {q.adr[27:0], q.io_s} : {q.adr[30:0], q.io_s[0]};
            else
              d.dat = I_QUAD_MODE ? {q.dat[27:0], q.io_s} : {q.dat[30:0], q.io_s[0]};
            d.cnt = (q.cnt < 7'd120) ? q.cnt + w : q.cnt;
            if (q.cmd.rd && d.cnt == q.cmd.alen)
            begin
              ld   = 1'b1;
              d.st = DS_OUT;
            end
          end
        DS_OUT:
          if (fall)
          begin
            d.drv = I_QUAD_MODE ? q.out[31:28] : {2'b00, q.out[31], 1'b0};
            d.oe  = I_QUAD_MODE ? 4'hf : 4'h2;
            d.out = I_QUAD_MODE ? {q.out[27:0], q.out[31:28]} : {q.out[30:0], q.out[31]};
          end
        DS_IGN: d.st = DS_IGN;
      endcase
    end
    // Read source loaded once; rotation repeats it
    if (ld)
    begin
      ea   = eff(d.adr, d.cmd.alen, q.bank);
      sect = ea[SECT_LSB +: SECT_BITS];
      stat[`FCP_STAT_WIP] = q.write_in_progress;
      stat[`FCP_STAT_WEL] = q.write_enable_latch;
      if (d.cmd.alen != 7'd0)
        d.last = ea;
      case (d.op)
        `FCP_OP_STAT:                        d.out = {4{stat}};
        `FCP_OP_BOOT_RD:                     d.out = fcp_bswap(q.boot);
        `FCP_OP_BANK_RD, `FCP_OP_BANK_RD2:   d.out = {4{q.bank}};
        `FCP_OP_DYN_RD, `FCP_OP_DYN_RD4:     d.out = {32{q.dynamic_protect_bit[sect]}};
        `FCP_OP_PP_RD, `FCP_OP_PP_RD4:       d.out = {32{q.persistent_protect_bit[sect]}};
        default:                             d.out = 32'h0;
      endcase
    end
    d.write_in_progress = (d.busy != 16'h0);
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge I_CORE_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      q      <= '0;
      q.st   <= DS_IDLE;
      q.sck_m <= 1'b0;
      q.cs_m <= 1'b1;
      q.cs_s <= 1'b1;
      q.bank <= `FCP_BANK_RST;
      q.bnv  <= `FCP_BANK_RST;
      q.boot <= `FCP_BOOT_RST;
      q.dynamic_protect_bit  <= '1;
      q.persistent_protect_bit  <= '1;
    end
    else
      q <= d;
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign LINK.d_o     = q.drv;
  assign LINK.d_oe    = q.oe;
  assign O_WIP        = q.write_in_progress;
  assign O_WEL        = q.write_enable_latch;
  assign O_BANK_REG   = q.bank;
  assign O_BANK_NV    = q.bnv;
  assign O_BOOT_CFG   = q.boot;
  assign O_BOOT_DELAY = q.boot[`FCP_BOOT_DLY_LSB +: 4];
  assign O_LAST_ADDR  = q.last;
endmodule

/* verilog/fcp_host.sv */
/*
  Controller end: frames one command per write of the command register,
  optionally preceded by a write-enable frame, and returns read bytes.
  Assumes a software port on the core clock; the flash samples the link.
*/
`include "fcp_map.svh"

module fcp_host #(
  parameter int HALF = `FCP_SCK_HALF,
  parameter int GAP  = `FCP_CS_GAP
) (
  input  wire logic        I_CORE_CLK,
  input  wire logic        I_RESETN,
  input  wire logic [7:0]  I_ADDR,
  input  wire logic [31:0] I_WDATA,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  output logic [31:0]      O_RDATA,
  output logic             O_BUSY,
  fcp_link_if.host         LINK
);
  import fcp_pkg::*;

  typedef struct packed {
    fcp_hst_t    st;
    logic [7:0]  div;
    logic        sclk;
    logic        csn;
    logic [3:0]  io_m;
    logic [3:0]  io_s;
    logic [7:0]  op;
    logic [2:0]  ab;
    logic [2:0]  db;
    logic [2:0]  rb;
    logic        quad;
    logic        aw;
    logic        wenp;
    logic [31:0] adr;
    logic [31:0] wdat;
    logic [31:0] rx;
    logic [31:0] rdat;
    logic [31:0] rd_q;
    logic [71:0] tx;
    logic [6:0]  pos;
    logic [6:0]  txb;
    logic [6:0]  tot;
    logic [3:0]  oe;
  } fcp_host_st_t;

  fcp_host_st_t q;
  fcp_host_st_t d;

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    logic [6:0]  w;
    logic [31:0] dd;
    logic [31:0] aal;
    logic [31:0] nrx;
    logic        ldm;
    logic        ldw;
    d   = q;
    w   = q.quad ? 7'd4 : 7'd1;
    dd  = q.wdat;
    aal = 32'h0;
    nrx = q.rx;
    ldm = 1'b0;
    ldw = 1'b0;
    d.io_m = LINK.io;
    d.io_s = q.io_m;
    // Register port: read data only in the cycle after the strobe
    d.rd_q = 32'h0;
    if (I_RD)
      case (I_ADDR)
        `FCP_REG_CMD:   d.rd_q = {13'h0, q.aw, q.quad, q.rb, q.db, q.ab, q.op};
        `FCP_REG_ADDR:  d.rd_q = q.adr;
        `FCP_REG_WDATA: d.rd_q = q.wdat;
        `FCP_REG_RDATA: d.rd_q = q.rdat;
        `FCP_REG_STAT:  d.rd_q = {31'h0, q.st != HS_IDLE};
        default:        d.rd_q = 32'h0;
      endcase
    if (I_WR)
      case (I_ADDR)
        `FCP_REG_ADDR:  d.adr  = I_WDATA;
        `FCP_REG_WDATA: d.wdat = I_WDATA;
        `FCP_REG_CMD:
          if (q.st == HS_IDLE)
          begin
            d.op   = I_WDATA[7:0];
            d.ab   = I_WDATA[`FCP_CMD_AB +: 3];
            d.db   = I_WDATA[`FCP_CMD_DB +: 3];
            d.rb   = I_WDATA[`FCP_CMD_RB +: 3];
            d.quad = I_WDATA[`FCP_CMD_QUAD];
            d.aw   = I_WDATA[`FCP_CMD_AWEN];
            d.wenp = I_WDATA[`FCP_CMD_AWEN];
            ldw    = I_WDATA[`FCP_CMD_AWEN];
            ldm    = ~I_WDATA[`FCP_CMD_AWEN];
          end
        default: d.adr = q.adr;
      endcase
    // Link sequencer, mode 0 clock from a divider
    unique case (q.st)
      HS_IDLE: d.div = 8'h0;
      HS_LOW:
        if (q.div == 8'(HALF - 1))
        begin
          d.div  = 8'h0;
          d.sclk = 1'b1;
          d.st   = HS_HIGH;
        end
        else
          d.div = q.div + 8'h1;
      HS_HIGH:
        if (q.div == 8'(HALF - 1))
        begin
          d.div  = 8'h0;
          d.sclk = 1'b0;
          if (q.pos >= q.txb)
            nrx = q.quad ? {q.rx[27:0], q.io_s} : {q.rx[30:0], q.io_s[1]};
          d.rx  = nrx;
          d.pos = q.pos + w;
          d.tx  = q.tx << w;
          if (d.pos >= q.txb)
            d.oe = 4'h0;
          if (d.pos == q.tot)
          begin
            d.csn = 1'b1;
            d.st  = HS_GAP;
            if (q.rb != 3'h0)
              d.rdat = fcp_bswap(nrx << {3'd4 - q.rb, 3'b000});
          end
          else
            d.st = HS_LOW;
        end
        else
          d.div = q.div + 8'h1;
      HS_GAP:
        if (q.div == 8'(GAP - 1))
        begin
          d.div = 8'h0;
          d.st  = HS_IDLE;
          if (q.wenp)
          begin
            d.wenp = 1'b0;
            ldm    = 1'b1;
          end
        end
        else
          d.div = q.div + 8'h1;
    endcase
    // Frame loading: write enable alone, or the programmed command
    if (ldw)
    begin
      d.tx  = {`FCP_OP_WEN, 64'h0};
      d.txb = 7'd8;
      d.tot = 7'd8;
    end
    if (ldm)
    begin
      if (d.op == `FCP_OP_BANK_WRNV || d.op == `FCP_OP_BANK_WRV ||
          d.op == `FCP_OP_BANK_WRVE)
        dd = {q.wdat[31:8], q.wdat[7:0] & ~`FCP_BANK_RSVD};
      aal   = (d.ab == 3'd4) ? d.adr : ((d.ab == 3'd3) ? {d.adr[23:0], 8'h0} : 32'h0);
      d.tx  = {d.op, aal, 32'h0} | ({40'h0, fcp_bswap(dd)} << {3'd4 - d.ab, 3'b000});
      d.txb = {4'(4'(d.ab) + 4'(d.db) + 4'd1), 3'b000};
      d.tot = {4'(4'(d.ab) + 4'(d.db) + 4'(d.rb) + 4'd1), 3'b000};
    end
    if (ldw || ldm)
    begin
      d.pos  = 7'd0;
      d.rx   = 32'h0;
      d.csn  = 1'b0;
      d.st   = HS_LOW;
      d.oe   = d.quad ? 4'hf : 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge I_CORE_CLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      q     <= '0;
      q.st  <= HS_IDLE;
      q.csn <= 1'b1;
    end
    else
      q <= d;
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign LINK.sclk = q.sclk;
  assign LINK.cs_n = q.csn;
  assign LINK.h_o  = q.quad ? q.tx[71:68] : {3'b000, q.tx[71]};
  assign LINK.h_oe = q.oe;
  assign O_RDATA   = q.rd_q;
  assign O_BUSY    = (q.st != HS_IDLE);
endmodule

/* verilog/fcp_link_if.sv */
/*
  Serial link between controller and flash: clock, select, four data lines.
  Assumes an idle line reads high when no end drives it.
*/
interface fcp_link_if;
  logic       sclk;
  logic       cs_n;
  logic [3:0] h_o;
  logic [3:0] h_oe;
  logic [3:0] d_o;
  logic [3:0] d_oe;
  logic [3:0] io;

  // Wire level from the two enables, pulled high when idle
  assign io = (h_oe & h_o) | (~h_oe & d_oe & d_o) | (~h_oe & ~d_oe);

  modport dev  (input sclk, cs_n, io, output d_o, d_oe);
  modport host (output sclk, cs_n, h_o, h_oe, input io);
endinterface

/* verilog/fcp_map.svh */
/*
  Constants of the flash configuration and protection command block:
  opcodes, field positions, reset values, timing counts and the offsets
  of the controller's own registers.
  Assumes inclusion by bare name from both ends of the link.
*/
`ifndef FCP_MAP_SVH
`define FCP_MAP_SVH

////////////////////////////////////////////////////////////////////////
// Opcodes
`define FCP_OP_WEN        8'h06
`define FCP_OP_STAT       8'h05
`define FCP_OP_BOOT_RD    8'h14
`define FCP_OP_BOOT_WR    8'h15
`define FCP_OP_BANK_RD    8'h16
`define FCP_OP_BANK_RD2   8'hc8
`define FCP_OP_BANK_WRNV  8'h18
`define FCP_OP_BANK_WRV   8'h17
`define FCP_OP_BANK_WRVE  8'hc5
`define FCP_OP_WIDE_ON    8'hb7
`define FCP_OP_WIDE_OFF   8'h29
`define FCP_OP_DYN_RD     8'hfa
`define FCP_OP_DYN_RD4    8'he0
`define FCP_OP_DYN_WR     8'hfb
`define FCP_OP_DYN_WR4    8'he1
`define FCP_OP_PP_RD      8'hfc
`define FCP_OP_PP_RD4     8'he2
`define FCP_OP_PP_PG      8'hfd
`define FCP_OP_PP_PG4     8'he3
`define FCP_OP_PP_ER      8'he4

////////////////////////////////////////////////////////////////////////
// Fields and reset values
`define FCP_BANK_EXT      7
`define FCP_BANK_RSVD     8'h7c
`define FCP_BANK_RST      8'h00
`define FCP_BOOT_RST      32'h00000000
`define FCP_BOOT_EN       0
`define FCP_BOOT_DLY_LSB  1
`define FCP_BOOT_STA_LSB  5
`define FCP_STAT_WIP      0
`define FCP_STAT_WEL      1

////////////////////////////////////////////////////////////////////////
// Timing
`define FCP_CORE_NS       50
`define FCP_LINK_NS       400
`define FCP_SCK_HALF      ((`FCP_LINK_NS / 2 + `FCP_CORE_NS - 1) / `FCP_CORE_NS)
`define FCP_CS_GAP        4
`define FCP_BUSY_NS       3200
`define FCP_BUSY_CYC      (`FCP_BUSY_NS / `FCP_CORE_NS)

////////////////////////////////////////////////////////////////////////
// Controller registers and command fields
`define FCP_REG_CMD       8'h00
`define FCP_REG_ADDR      8'h04
`define FCP_REG_WDATA     8'h08
`define FCP_REG_RDATA     8'h0c
`define FCP_REG_STAT      8'h10
`define FCP_CMD_AB        8
`define FCP_CMD_DB        11
`define FCP_CMD_RB        14
`define FCP_CMD_QUAD      17
`define FCP_CMD_AWEN      18

`endif

/* verilog/fcp_pkg.sv */
/*
  Types shared by both ends of the flash configuration command link.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package fcp_pkg;
  typedef enum logic [4:0] {
    DS_IDLE = 5'b00001,
    DS_OPC  = 5'b00010,
    DS_ARG  = 5'b00100,
    DS_OUT  = 5'b01000,
    DS_IGN  = 5'b10000
  } fcp_dst_t;

  typedef enum logic [3:0] {
    HS_IDLE = 4'b0001,
    HS_LOW  = 4'b0010,
    HS_HIGH = 4'b0100,
    HS_GAP  = 4'b1000
  } fcp_hst_t;

  typedef struct packed {
    logic       ok;
    logic       write_enable_latch;
    logic       rd;
    logic [6:0] alen;
    logic [6:0] dlen;
  } fcp_cmd_t;

  // Lowest byte first on the wire
  function automatic logic [31:0] fcp_bswap(input logic [31:0] v);
    return {v[7:0], v[15:8], v[23:16], v[31:24]};
  endfunction
endpackage
